// File: src/swm_pkg.sv
`default_nettype none
// ============================================================
// shared constants for the single-wire bus master
package swm_pkg;
    // clock and microsecond tick
    localparam int CLK_HZ = 10_000_000;
    localparam int US_HZ = 1_000_000;
    localparam int CYC_PER_US = CLK_HZ / US_HZ;
    localparam int DIV_W = 4;
    localparam logic [DIV_W-1:0] TICK_LAST = DIV_W'(CYC_PER_US - 1);

    // phase timer counts whole microseconds
    localparam int TMR_W = 10;
    typedef logic [TMR_W-1:0] swm_us_t;

    // nominal timing in microseconds
    localparam int RST_LOW_US = 511;
    localparam int RST_REL_US = 512;
    localparam int W0_LOW_US = 100;
    localparam int SLOT_US = 117;
    localparam int W1_LOW_US = 5;
    localparam int RD_SAMPLE_US = 13;
    localparam int PRES_FIRST_US = 15;
    localparam int PRES_LAST_US = 300;

    // documented limits in microseconds
    localparam int RST_LOW_MIN_US = 480;
    localparam int RST_REL_MIN_US = 480;
    localparam int W0_LOW_MIN_US = 60;
    localparam int W0_LOW_MAX_US = 120;
    localparam int SLOT_MIN_US = 60;
    localparam int SLOT_MAX_US = 120;
    localparam int LOW1_MIN_US = 1;
    localparam int LOW1_MAX_US = 15;
    localparam int RD_SAMPLE_MAX_US = 15;

    // command codes and fifo geometry
    localparam int CMD_W = 2;
    typedef logic [CMD_W-1:0] swm_cmd_t;
    localparam swm_cmd_t CMD_RESET = 2'h0;
    localparam swm_cmd_t CMD_WRITE0 = 2'h1;
    localparam swm_cmd_t CMD_WRITE1 = 2'h2;
    localparam swm_cmd_t CMD_READ = 2'h3;
    localparam int FIFO_DEPTH = 16;
endpackage
`default_nettype wire

// File: src/swm_stream_if.sv
`default_nettype none
// ============================================================
// valid/ready word stream between the block's own modules
interface swm_stream_if #(parameter int W = 2);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: src/swm_fifo.sv
`default_nettype none
// ============================================================
// synchronous fifo, registered full and empty flags
module swm_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,     // system clock
    input wire logic i_rst_n,   // async reset, low active
    swm_stream_if.snk wr,       // filling side
    swm_stream_if.src rd        // draining side
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
    localparam logic [CW-1:0] CNT_ZERO = '0;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic in_rdy;
    logic out_vld;
    logic push;
    logic pop;
    logic [CW-1:0] next_count;

    // handshakes on both sides
    assign push = wr.valid && in_rdy;
    assign pop = out_vld && rd.ready;
    assign wr.ready = in_rdy;
    assign rd.valid = out_vld;
    assign rd.data = mem[rd_ptr];

    always_comb
    begin
        next_count = count;
        if (push && !pop)
            next_count = count + CW'(1);
        else if (pop && !push)
            next_count = count - CW'(1);
    end

    // storage, no reset needed on the array
    always_ff @(posedge i_clk)
    begin
        if (push)
            mem[wr_ptr] <= wr.data;
    end

    // pointers and flags; flags registered so ready is a flop
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_rdy <= 1'b0;
            out_vld <= 1'b0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + AW'(1);
            if (pop)
                rd_ptr <= rd_ptr + AW'(1);
            count <= next_count;
            in_rdy <= (next_count != CNT_FULL);
            out_vld <= (next_count != CNT_ZERO);
        end
    end
endmodule // swm_fifo
`default_nettype wire

// File: src/swm_master.sv
// Functional notes
// - reset low pulse at least 480us, nominal 511
// - release recovery at least 480us, nominal 512
// - zero bit low 60 to 120us, nominal 100
// - zero slot up to 120us, nominal 117
// - one/read low 1 to 15us, nominal 5
// - one/read slot 60 to 120us, nominal 117
`default_nettype none
// ============================================================
// single-wire bus master: reset/presence, write and read slots
module swm_master
    import swm_pkg::*;
#(
    parameter int P_RST_LOW_US = swm_pkg::RST_LOW_US,  // reset low length
    parameter int P_RST_REL_US = swm_pkg::RST_REL_US   // recovery length
) (
    input wire logic i_clk,                  // 10 MHz clock
    input wire logic i_rst_n,                // async reset, low active
    input wire logic i_cmd_valid,            // command offered
    input wire swm_pkg::swm_cmd_t i_cmd,     // command code
    output logic o_cmd_ready,                // fifo can take a command
    input wire logic i_wire_i,               // wire level from pad
    output logic o_wire_o,                   // wire drive value, always 0
    output logic o_wire_oe,                  // high while pulling low
    output logic o_busy,                     // a slot is in progress
    output logic o_rd_valid,                 // pulse: read bit ready
    output logic o_rd_bit,                   // sampled read bit
    output logic o_pres_valid,               // pulse: reset sequence done
    output logic o_presence                  // a slave answered
);
    import swm_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_REL} swm_state_e;

    localparam swm_us_t RST_LOW_LEN = TMR_W'(P_RST_LOW_US);
    localparam swm_us_t RST_REL_LEN = TMR_W'(P_RST_REL_US);
    localparam swm_us_t W0_LOW_LEN = TMR_W'(W0_LOW_US);
    localparam swm_us_t W0_REL_LEN = TMR_W'(SLOT_US - W0_LOW_US);
    localparam swm_us_t W1_LOW_LEN = TMR_W'(W1_LOW_US);
    localparam swm_us_t W1_REL_LEN = TMR_W'(SLOT_US - W1_LOW_US);
    localparam swm_us_t RD_SAMPLE_AT = TMR_W'(RD_SAMPLE_US - W1_LOW_US - 1);
    localparam swm_us_t PRES_FIRST = TMR_W'(PRES_FIRST_US);
    localparam swm_us_t PRES_LAST = TMR_W'(PRES_LAST_US);

    // true on the tick that closes a phase of the given length
    function automatic logic phase_end(input swm_us_t tmr, input swm_us_t len);
        phase_end = (tmr == len - TMR_W'(1));
    endfunction

    swm_state_e state;
    swm_cmd_t cur_cmd;
    swm_us_t tmr;
    swm_us_t low_len;
    swm_us_t rel_len;
    logic [DIV_W-1:0] div;
    logic tick;
    logic wire_m;
    logic wire_s;
    logic pres_seen;
    logic start;

    swm_stream_if #(.W(CMD_W)) cmd_in ();
    swm_stream_if #(.W(CMD_W)) cmd_out ();

    // ============================================================
    // command fifo; gated by our own ready so a request held one cycle past its accept lands once
    assign cmd_in.valid = i_cmd_valid && o_cmd_ready;
    assign cmd_in.data = i_cmd;
    assign cmd_out.ready = (state == ST_IDLE);
    assign start = cmd_out.valid && cmd_out.ready;

    swm_fifo #(.WIDTH(CMD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .wr(cmd_in),
        .rd(cmd_out)
    );

    // fifo ready is itself a flop, register it once more, dropped for the cycle after each accept
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_cmd_ready <= 1'b0;
        else
            o_cmd_ready <= cmd_in.ready && !(cmd_in.valid && o_cmd_ready);
    end

    // ============================================================
    // wire input synchroniser, the pad is asynchronous
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wire_m <= 1'b1;
            wire_s <= 1'b1;
        end
        else
        begin
            wire_m <= i_wire_i;
            wire_s <= wire_m;
        end
    end

    // ============================================================
    // microsecond divider, restarted per phase so lengths are exact
    assign tick = (div == TICK_LAST);

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            div <= '0;
        else if (start || tick || state == ST_IDLE)
            div <= '0;
        else
            div <= div + DIV_W'(1);
    end

    // ============================================================
    // slot sequencer: low phase, then released phase
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state <= ST_IDLE;
            cur_cmd <= CMD_RESET;
            tmr <= '0;
            low_len <= W1_LOW_LEN;
            rel_len <= W1_REL_LEN;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    tmr <= '0;
                    if (start)
                    begin
                        cur_cmd <= cmd_out.data;
                        state <= ST_LOW;
                        case (cmd_out.data)
                            CMD_RESET:
                            begin
                                low_len <= RST_LOW_LEN;
                                rel_len <= RST_REL_LEN;
                            end
                            CMD_WRITE0:
                            begin
                                low_len <= W0_LOW_LEN;
                                rel_len <= W0_REL_LEN;
                            end
                            default:
                            begin
                                low_len <= W1_LOW_LEN;
                                rel_len <= W1_REL_LEN;
                            end
                        endcase
                    end
                end
                ST_LOW:
                    if (tick)
                    begin
                        if (phase_end(tmr, low_len))
                        begin
                            state <= ST_REL;
                            tmr <= '0;
                        end
                        else
                            tmr <= tmr + TMR_W'(1);
                    end
                ST_REL:
                    if (tick)
                    begin
                        if (phase_end(tmr, rel_len))
                            state <= ST_IDLE;
                        else
                            tmr <= tmr + TMR_W'(1);
                    end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // ============================================================
    // pin drive and busy, registered from the next state
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_wire_o <= 1'b0;
            o_wire_oe <= 1'b0;
            o_busy <= 1'b0;
        end
        else
        begin
            o_wire_o <= 1'b0;
            if (start)
            begin
                o_wire_oe <= 1'b1;
                o_busy <= 1'b1;
            end
            else if (state == ST_LOW && tick && phase_end(tmr, low_len))
                o_wire_oe <= 1'b0;
            else if (state == ST_REL && tick && phase_end(tmr, rel_len))
                o_busy <= 1'b0;
        end
    end

    // ============================================================
    // results: presence window and read sample
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pres_seen <= 1'b0;
            o_presence <= 1'b0;
            o_pres_valid <= 1'b0;
            o_rd_valid <= 1'b0;
            o_rd_bit <= 1'b0;
        end
        else
        begin
            o_pres_valid <= 1'b0;
            o_rd_valid <= 1'b0;
            if (start)
                pres_seen <= 1'b0;
            // window from 15us to 300us after release covers slave delay and pulse length
            if (state == ST_REL && cur_cmd == CMD_RESET && !wire_s
                && tmr >= PRES_FIRST && tmr <= PRES_LAST)
                pres_seen <= 1'b1;
            if (state == ST_REL && tick && phase_end(tmr, rel_len)
                && cur_cmd == CMD_RESET)
            begin
                o_presence <= pres_seen;
                o_pres_valid <= 1'b1;
            end
            // sampled shortly before 15us so a slave zero is still held
            if (state == ST_REL && tick && tmr == RD_SAMPLE_AT
                && cur_cmd == CMD_READ)
            begin
                o_rd_bit <= wire_s;
                o_rd_valid <= 1'b1;
            end
        end
    end

    // ============================================================
    // checks: cycle counters of low time, release time, slot time
    localparam int RST_LOW_MIN_CYC = RST_LOW_MIN_US * CYC_PER_US;
    localparam int RST_REL_MIN_CYC = RST_REL_MIN_US * CYC_PER_US;
    localparam int W0_LOW_MIN_CYC = W0_LOW_MIN_US * CYC_PER_US;
    localparam int W0_LOW_MAX_CYC = W0_LOW_MAX_US * CYC_PER_US;
    localparam int SLOT_MIN_CYC = SLOT_MIN_US * CYC_PER_US;
    localparam int SLOT_MAX_CYC = SLOT_MAX_US * CYC_PER_US;
    localparam int LOW1_MIN_CYC = LOW1_MIN_US * CYC_PER_US;
    localparam int LOW1_MAX_CYC = LOW1_MAX_US * CYC_PER_US;
    localparam int RD_MAX_CYC = RD_SAMPLE_MAX_US * CYC_PER_US;

    int low_cyc;
    int rel_cyc;
    int slot_cyc;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            low_cyc <= 0;
            rel_cyc <= 0;
            slot_cyc <= 0;
        end
        else
        begin
            low_cyc <= o_wire_oe ? low_cyc + 1 : 0;
            rel_cyc <= (o_busy && !o_wire_oe) ? rel_cyc + 1 : 0;
            slot_cyc <= o_busy ? slot_cyc + 1 : 0;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    AST_RST_LOW: assert property ($fell(o_wire_oe) && cur_cmd == CMD_RESET
        |-> low_cyc >= RST_LOW_MIN_CYC)
        else $error("reset low pulse too short");
    AST_RST_REL: assert property ($fell(o_busy) && cur_cmd == CMD_RESET
        |-> rel_cyc >= RST_REL_MIN_CYC && !o_wire_oe)
        else $error("reset recovery too short");
    AST_W0_LOW: assert property ($fell(o_wire_oe) && cur_cmd == CMD_WRITE0
        |-> low_cyc >= W0_LOW_MIN_CYC && low_cyc <= W0_LOW_MAX_CYC)
        else $error("zero bit low time out of range");
    AST_W0_SLOT: assert property ($fell(o_busy) && cur_cmd == CMD_WRITE0
        |-> slot_cyc >= W0_LOW_MIN_CYC && slot_cyc <= SLOT_MAX_CYC)
        else $error("zero bit slot length out of range");
    AST_W1_LOW: assert property ($fell(o_wire_oe) && cur_cmd[1]
        |-> low_cyc >= LOW1_MIN_CYC && low_cyc <= LOW1_MAX_CYC)
        else $error("one or read low time out of range");
    AST_W1_SLOT: assert property ($fell(o_busy) && cur_cmd[1]
        |-> slot_cyc >= SLOT_MIN_CYC && slot_cyc <= SLOT_MAX_CYC)
        else $error("one or read slot length out of range");
    AST_PRES: assert property (o_pres_valid
        |-> cur_cmd == CMD_RESET && o_presence == $past(pres_seen) && !o_busy)
        else $error("presence flag not from reset window");
    AST_RD_SAMPLE: assert property (o_rd_valid
        |-> cur_cmd == CMD_READ && slot_cyc < RD_MAX_CYC && o_rd_bit == $past(wire_s))
        else $error("read sample misplaced");

    COV_RESET: cover property (o_pres_valid && o_presence);
    COV_WRITE0: cover property ($fell(o_busy) && cur_cmd == CMD_WRITE0);
    COV_READ0: cover property (o_rd_valid && !o_rd_bit);
    COV_FULL: cover property (!o_cmd_ready && i_cmd_valid);
endmodule // swm_master
`default_nettype wire

// File: sim/swm_slave_model.sv
`default_nettype none
// ============================================================
// behavioural slave on the shared wire: presence and read-zero
module swm_slave_model #(
    parameter int P_PDH_CYC = 300,  // wait before presence, 30us
    parameter int P_PDL_CYC = 1200, // presence low, 120us
    parameter int P_REL_CYC = 300,  // zero hold in a read slot, 30us
    parameter int P_RST_CYC = 4000  // a low this long counts as reset
) (
    input wire logic i_clk,      // system clock
    input wire logic i_rst_n,    // async reset, low active
    input wire logic i_wire,     // resolved wire level
    input wire logic i_present,  // answer reset with presence
    input wire logic i_resp_bit, // bit returned in read slots
    output logic o_drive         // high while pulling wire low
);
    timeunit 1ns;
    timeprecision 1ns;
    typedef enum logic [1:0] {SWS_IDLE, SWS_WAIT, SWS_PRES, SWS_ZERO} swm_slave_e;
    swm_slave_e state;
    int cnt;
    int low_cnt;
    logic wire_q;
    // one state machine; a slot start is any fall we did not cause
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state <= SWS_IDLE;
            cnt <= 0;
            low_cnt <= 0;
            wire_q <= 1'b1;
            o_drive <= 1'b0;
        end
        else
        begin
            wire_q <= i_wire;
            low_cnt <= i_wire ? 0 : low_cnt + 1;
            cnt <= cnt + 1;
            case (state)
                SWS_IDLE:
                begin
                    cnt <= 0;
                    if (wire_q && !i_wire && !i_resp_bit)
                    begin
                        state <= SWS_ZERO;
                        o_drive <= 1'b1;
                    end
                    else if (!wire_q && i_wire && low_cnt >= P_RST_CYC && i_present)
                        state <= SWS_WAIT;
                end
                SWS_WAIT:
                if (cnt == P_PDH_CYC - 1)
                begin
                    state <= SWS_PRES;
                    o_drive <= 1'b1;
                    cnt <= 0;
                end
                SWS_PRES:
                if (cnt == P_PDL_CYC - 1)
                begin
                    state <= SWS_IDLE;
                    o_drive <= 1'b0;
                end
                default:
                if (cnt == P_REL_CYC - 2)
                begin
                    state <= SWS_IDLE;
                    o_drive <= 1'b0;
                end
            endcase
        end
    end
endmodule // swm_slave_model
`default_nettype wire

// File: sim/single_wire_bus_master_timing_tb.sv
`default_nettype none
// ============================================================
// self-checking bench for the single-wire bus master
module single_wire_bus_master_timing_tb
    import swm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    swm_cmd_t cmd = CMD_RESET;
    logic present = 1'b1;
    logic resp_bit = 1'b1;
    logic cmd_ready, wire_oe, busy, rd_valid, rd_bit, pres_valid, presence, slave_drv;
    logic wire_o;
    wire logic bus_line;
    int compares = 0;
    int miscompares = 0;
    int oe_rises = 0;
    logic oe_q = 1'b0;
    // open-drain wire with pull-up: low if anyone pulls, master drives its value
    assign bus_line = ~((wire_oe & ~wire_o) | slave_drv);
    always #50 clk = ~clk;
    always @(negedge clk)
    begin
        oe_q <= wire_oe;
        if (wire_oe === 1'b1 && oe_q !== 1'b1)
            oe_rises <= oe_rises + 1;
    end
    swm_master DUT (.i_clk(clk), .i_rst_n(rst_n), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
        .o_cmd_ready(cmd_ready), .i_wire_i(bus_line), .o_wire_o(wire_o), .o_wire_oe(wire_oe),
        .o_busy(busy), .o_rd_valid(rd_valid), .o_rd_bit(rd_bit),
        .o_pres_valid(pres_valid), .o_presence(presence));
    swm_slave_model slave (.i_clk(clk), .i_rst_n(rst_n), .i_wire(bus_line),
        .i_present(present), .i_resp_bit(resp_bit), .o_drive(slave_drv));
    // ============================================================
    // reporting
    task automatic wrap_up();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %0d seen %0d", name, exp, got);
        end
    endtask
    task automatic chk_rng(input string name, input int lo, input int hi, input int got);
        compares++;
        if (got < lo || got > hi)
        begin
            miscompares++;
            $display("BAD %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask
    task automatic hang(input string name);
        miscompares++;
        $display("BAD %s expected done seen timeout", name);
        wrap_up();
    endtask
    // ============================================================
    // command push and slot measurement, all at falling edges
    task automatic push(input swm_cmd_t c);
        int n;
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd = c;
        for (n = 0; n < 200 && cmd_ready !== 1'b1; n++)
            @(negedge clk);
        if (n == 200)
            hang("cmd accept");
        @(negedge clk);
        cmd_valid = 1'b0;
    endtask
    task automatic run(input swm_cmd_t c, output int low, output int slot,
        output logic rs, output logic rb, output logic ps, output logic pr);
        int n;
        rs = 0;
        rb = 0;
        ps = 0;
        pr = 0;
        push(c);
        for (n = 0; n < 20 && wire_oe !== 1'b1; n++)
            @(negedge clk);
        if (n == 20)
            hang("slot start");
        chk("drive value", 0, wire_o);
        for (low = 0; wire_oe === 1'b1 && low < 6000; low++)
            @(negedge clk);
        // busy rises with oe, so slot length counts from the same edge
        for (slot = low; busy === 1'b1 && slot < 12000; slot++)
        begin
            @(negedge clk);
            if (rd_valid === 1'b1)
            begin
                rs = 1;
                rb = rd_bit;
            end
            if (pres_valid === 1'b1)
            begin
                ps = 1;
                pr = presence;
            end
        end
        if (slot >= 12000)
            hang("slot end");
    endtask
    // ============================================================
    // scenarios
    task automatic t_reset(input logic p);
        int low, slot;
        logic rs, rb, ps, pr;
        present = p;
        run(CMD_RESET, low, slot, rs, rb, ps, pr);
        chk("reset low cycles", RST_LOW_US * CYC_PER_US, low);
        chk_rng("recovery cycles", RST_REL_MIN_US * CYC_PER_US, RST_REL_US * CYC_PER_US + 4,
            slot - low);
        chk("presence pulse", 1, ps);
        chk("presence flag", p, pr);
        $display("reset test done, slave present %0d", p);
    endtask
    task automatic t_write0();
        int low, slot;
        logic rs, rb, ps, pr;
        run(CMD_WRITE0, low, slot, rs, rb, ps, pr);
        chk("zero low cycles", W0_LOW_US * CYC_PER_US, low);
        chk_rng("zero slot cycles", W0_LOW_US * CYC_PER_US, SLOT_MAX_US * CYC_PER_US,
            slot);
        $display("write zero test done");
    endtask
    task automatic t_write1();
        int low, slot;
        logic rs, rb, ps, pr;
        run(CMD_WRITE1, low, slot, rs, rb, ps, pr);
        chk("one low cycles", W1_LOW_US * CYC_PER_US, low);
        chk_rng("one slot cycles", SLOT_MIN_US * CYC_PER_US, SLOT_MAX_US * CYC_PER_US,
            slot);
        chk("read pulse in write", 0, rs);
        $display("write one test done");
    endtask
    task automatic t_read(input logic b);
        int low, slot;
        logic rs, rb, ps, pr;
        resp_bit = b;
        run(CMD_READ, low, slot, rs, rb, ps, pr);
        resp_bit = 1'b1;
        chk("read low cycles", W1_LOW_US * CYC_PER_US, low);
        chk_rng("read slot cycles", SLOT_MIN_US * CYC_PER_US, SLOT_MAX_US * CYC_PER_US,
            slot);
        chk("read pulse", 1, rs);
        chk("read bit", b, rb);
        $display("read test done, bit %0d", b);
    endtask
    // fill the queue until it refuses, then let it drain empty
    task automatic t_fill();
        int base, pushes, idle, n;
        base = oe_rises;
        pushes = 0;
        idle = 0;
        @(negedge clk);
        cmd = CMD_WRITE1;
        cmd_valid = 1'b1;
        while (idle < 20)
        begin
            if (cmd_ready === 1'b1)
            begin
                pushes++;
                idle = 0;
            end
            else
                idle++;
            @(negedge clk);
        end
        cmd_valid = 1'b0;
        chk_rng("queued commands", FIFO_DEPTH, FIFO_DEPTH + 2, pushes);
        for (n = 0; n < 30000 && !(oe_rises - base == pushes && busy === 1'b0
            && cmd_ready === 1'b1); n++)
            @(negedge clk);
        if (n == 30000)
            hang("queue drain");
        chk("slots run", pushes, oe_rises - base);
        $display("fill and drain test done");
    endtask
    // reset in mid slot must drop the wire at once
    task automatic t_abort();
        int n;
        push(CMD_WRITE0);
        for (n = 0; n < 120 && wire_oe !== 1'b1; n++)
            @(negedge clk);
        if (n == 120)
            hang("abort slot start");
        rst_n = 1'b0;
        @(negedge clk);
        chk("oe in reset", 0, wire_oe);
        chk("ready in reset", 0, cmd_ready);
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        $display("abort test done");
    endtask
    // ============================================================
    // main sequence
    initial
    begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        t_reset(1'b1);
        t_reset(1'b0);
        t_reset(1'b1);
        t_write0();
        t_write1();
        t_read(1'b0);
        t_read(1'b1);
        t_read(1'b0);
        t_fill();
        t_abort();
        t_write1();
        wrap_up();
    end
endmodule // single_wire_bus_master_timing_tb
`default_nettype wire
